// file: rtl/pmr_pkg.sv
// Package: register map, field layout and reset values of the PM register bank
// Operation
// - Capability bit 9 reads 1: D1 power state supported.
// - Capability bits 8 to 6 always read 000.
// - Capability bit 5 reads 1: device-specific initialization needed.
// - Capability bit 4 reads 0: function supplies own auxiliary power.
// - Capability bit 3 reads 0: no bus clock needed for wake.
// - Capability version bits 2 to 0 read 001.
// - Control/status resets to 0000h on bus reset only, not on D3hot exit.
// - Wake status bit 15 sets on every wake event, enabled or not.
// - Writing 1 to bit 15 clears it and releases wake, unless a wake event lands in the same cycle (set wins); 0 does nothing.
// - Control/status data scale bits 14 to 13 read zero.
// - Control/status data select bits 12 to 9 read zero.
// - Bit 8 wake enable gates the wake output; cleared means never asserted.
// - Control/status bits 7 to 5 and 3 to 2 read zero.
// - Control/status bit 4 dynamic-data wake enable reads zero.
// - Power-state bits 1 to 0 report and set state: D0, D1, D2, D3hot.
// - Bridge support extensions byte is read-only, value C0h.
// - Extensions bit 7 reads 1: bus power and clock control.
// - Extensions bit 6 reads 1, bits 5 to 0 read zero.
package pmr_pkg;

  // Register indices; byte address on the bus is four times the index
  localparam logic [7:0]  CAP_IDX  = 8'hA2;
  localparam logic [7:0]  CSR_IDX  = 8'hA4;
  localparam logic [7:0]  EXT_IDX  = 8'hA6;
  localparam logic [11:0] CAP_ADDR = {2'h0, CAP_IDX, 2'h0};
  localparam logic [11:0] CSR_ADDR = {2'h0, CSR_IDX, 2'h0};
  localparam logic [11:0] EXT_ADDR = {2'h0, EXT_IDX, 2'h0};

  // Control/status field positions
  localparam int WS_BIT = 15;
  localparam int WE_BIT = 8;
  localparam int PS_LSB = 0;
  localparam int PS_MSB = 1;

  // Capability low bits: d1_supported, reserved, init, aux_power_flag,
  // wake_needs_bus_clock, version 001
  localparam logic [9:0]  CAP_LO   = 10'h221;
  localparam logic [15:0] CSR_RST  = 16'h0000;
  localparam logic [7:0]  EXT_VAL  = 8'hC0;

  typedef enum logic [1:0] {
    PMR_D0,
    PMR_D1,
    PMR_D2,
    PMR_D3HOT
  } pmr_pstate_t;

endpackage : pmr_pkg

// file: rtl/pmr_regs.sv
// PCI power-management register bank behind an AHB-Lite slave port
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps

module pmr_regs #(
  parameter logic [5:0] CAP_HI = 6'h00   // Upper capability bits, kept outside
) (
  input  wire logic        hclk,         // Bus clock, 250 MHz
  input  wire logic        hresetn,      // Bus reset, async, active low
  input  wire logic        hsel,         // Slave select
  input  wire logic [31:0] haddr,        // Byte address
  input  wire logic [1:0]  htrans,       // Transfer type
  input  wire logic        hwrite,       // Write when high
  input  wire logic [2:0]  hsize,        // Transfer size, word only
  input  wire logic [31:0] hwdata,       // Write data
  input  wire logic        hready,       // Bus ready
  output logic      [31:0] hrdata,       // Read data
  output logic             hreadyout,    // Slave ready
  output logic             hresp,        // Response, always OKAY
  input  wire logic        wake_event,   // Function would signal wake, pulse
  output logic             wake_n,       // Wake request, active low
  output logic      [1:0]  power_state,  // Current power state
  output logic             func_reset    // Internal reset pulse on D3hot exit
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus address phase capture

  logic        aphase;
  logic        wr_q;
  logic        rd_q;
  logic [11:0] addr_q;

  assign aphase    = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
      addr_q <= 12'h000;
    end
    else
    begin
      wr_q   <= aphase && hwrite;
      rd_q   <= aphase && !hwrite;
      addr_q <= aphase ? haddr[11:0] : addr_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control/status state

  logic                 csr_wr;
  logic                 ws_q;
  logic                 ws_d;
  logic                 we_q;
  logic                 we_d;
  pmr_pkg::pmr_pstate_t ps_q;
  pmr_pkg::pmr_pstate_t ps_d;
  logic                 frst_d;

  // Only the control/status word takes writes; others drop them
  assign csr_wr = wr_q && (addr_q == pmr_pkg::CSR_ADDR);

  always_comb
  begin
    we_d   = we_q;
    ps_d   = ps_q;
    frst_d = 1'b0;
    // An event in the clearing cycle is kept: set wins
    ws_d   = wake_event || ws_q;
    if (csr_wr)
    begin
      if (hwdata[pmr_pkg::WS_BIT])
        ws_d = wake_event;
      we_d = hwdata[pmr_pkg::WE_BIT];
      ps_d = pmr_pkg::pmr_pstate_t'(hwdata[pmr_pkg::PS_MSB:pmr_pkg::PS_LSB]);
      frst_d = (ps_q == pmr_pkg::PMR_D3HOT) && (ps_d == pmr_pkg::PMR_D0);
    end
  end

  // Only the bus reset clears these; the D3hot exit reset does not reach
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ws_q <= pmr_pkg::CSR_RST[pmr_pkg::WS_BIT];
      we_q <= pmr_pkg::CSR_RST[pmr_pkg::WE_BIT];
      ps_q <= pmr_pkg::PMR_D0;
    end
    else
    begin
      ws_q <= ws_d;
      we_q <= we_d;
      ps_q <= ps_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs to the function

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wake_n      <= 1'b1;
      power_state <= 2'h0;
      func_reset  <= 1'b0;
    end
    else
    begin
      wake_n      <= !(ws_d && we_d);
      power_state <= ps_d;
      func_reset  <= frst_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  // Built from next-state values so a read right after a write sees it
  function automatic logic [31:0] rd_word(
    input logic [11:0]          a,
    input logic                 ws,
    input logic                 we,
    input pmr_pkg::pmr_pstate_t ps
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (a)
      pmr_pkg::CAP_ADDR: w[15:0] = {CAP_HI, pmr_pkg::CAP_LO};
      pmr_pkg::CSR_ADDR: w[15:0] = {ws, 6'h00, we, 6'h00, ps};
      pmr_pkg::EXT_ADDR: w[7:0] = pmr_pkg::EXT_VAL;
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction : rd_word

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (aphase && !hwrite)
      hrdata <= rd_word(haddr[11:0], ws_d, we_d, ps_d);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence csr_write_s;
    wr_q && (addr_q == pmr_pkg::CSR_ADDR);
  endsequence

  sequence clear_write_s;
    csr_write_s ##0 (hwdata[15] && !wake_event);
  endsequence

  sequence d3_exit_s;
    csr_write_s ##0 (ps_q == pmr_pkg::PMR_D3HOT) ##0 (hwdata[1:0] == 2'h0);
  endsequence

  cap_low_bits_a: assert property (
    rd_q && (addr_q == pmr_pkg::CAP_ADDR) |->
      hrdata[9] && (hrdata[8:6] == 3'h0) && hrdata[5] && !hrdata[4]
      && !hrdata[3] && (hrdata[2:0] == 3'h1) && (hrdata[31:16] == 16'h0))
    else $error("capability low bits wrong");

  csr_reserved_zero_a: assert property (
    rd_q && (addr_q == pmr_pkg::CSR_ADDR) |->
      (hrdata[14:9] == 6'h00) && (hrdata[7:2] == 6'h00)
      && (hrdata[31:16] == 16'h0))
    else $error("control/status constant field not zero");

  ext_byte_a: assert property (
    rd_q && (addr_q == pmr_pkg::EXT_ADDR) |-> (hrdata == 32'h0000_00C0))
    else $error("bridge extension byte not C0h");

  wake_set_a: assert property (
    wake_event |=> ws_q ##1 (ws_q || $past(csr_wr)))
    else $error("wake status not set by event");

  wake_clear_a: assert property (
    clear_write_s |=> !ws_q && wake_n)
    else $error("wake status not cleared by write of one");

  wake_gate_a: assert property (
    !we_q |-> wake_n)
    else $error("wake driven while disabled");

  wake_drive_a: assert property (
    ws_q && we_q |-> !wake_n)
    else $error("wake not driven with status and enable set");

  pstate_write_a: assert property (
    csr_write_s |=> (power_state == $past(hwdata[1:0]))
      && (ps_q == $past(hwdata[1:0])) && (we_q == $past(hwdata[8])))
    else $error("power state or enable not written");

  d3_exit_keep_a: assert property (
    d3_exit_s |=> func_reset && (ps_q == pmr_pkg::PMR_D0)
      && (ws_q == ($past(ws_q) && !$past(hwdata[15]) || $past(wake_event)))
      ##1 !func_reset)
    else $error("D3hot exit disturbed the control/status word");

  ro_write_a: assert property (
    wr_q && (addr_q != pmr_pkg::CSR_ADDR) && !wake_event |=>
      $stable(ws_q) && $stable(we_q) && $stable(ps_q))
    else $error("write to read-only word changed state");

  ////////////////////////////////////////////////////////////////////////////
  // Field-by-field read checks; hrdata and the state flops load together,
  // so a read data phase must mirror the flops exactly

  sequence cap_read_s;
    rd_q && (addr_q == pmr_pkg::CAP_ADDR);
  endsequence

  sequence csr_read_s;
    rd_q && (addr_q == pmr_pkg::CSR_ADDR);
  endsequence

  sequence ext_read_s;
    rd_q && (addr_q == pmr_pkg::EXT_ADDR);
  endsequence

  sequence ws_write1_s;
    csr_write_s ##0 hwdata[pmr_pkg::WS_BIT];
  endsequence

  sequence ws_write0_s;
    csr_write_s ##0 !hwdata[pmr_pkg::WS_BIT];
  endsequence

  cap_d1_a: assert property (
    cap_read_s |-> hrdata[9])
    else $error("capability D1 bit not set");

  cap_rsvd_a: assert property (
    cap_read_s |-> (hrdata[8:6] == 3'h0))
    else $error("capability reserved bits not zero");

  cap_init_a: assert property (
    cap_read_s |-> hrdata[5])
    else $error("capability init bit not set");

  cap_aux_a: assert property (
    cap_read_s |-> !hrdata[4])
    else $error("capability aux power bit set");

  cap_clk_a: assert property (
    cap_read_s |-> !hrdata[3])
    else $error("capability bus clock bit set");

  cap_version_a: assert property (
    cap_read_s |-> (hrdata[2:0] == 3'h1))
    else $error("capability version wrong");

  csr_scale_a: assert property (
    csr_read_s |-> (hrdata[14:13] == 2'h0))
    else $error("data scale field not zero");

  csr_select_a: assert property (
    csr_read_s |-> (hrdata[12:9] == 4'h0))
    else $error("data select field not zero");

  csr_dyn_a: assert property (
    csr_read_s |-> !hrdata[4])
    else $error("dynamic data wake enable set");

  csr_rsvd_hi_a: assert property (
    csr_read_s |-> (hrdata[7:5] == 3'h0))
    else $error("control/status bits 7 to 5 not zero");

  csr_rsvd_lo_a: assert property (
    csr_read_s |-> (hrdata[3:2] == 2'h0))
    else $error("control/status bits 3 to 2 not zero");

  csr_ws_read_a: assert property (
    csr_read_s |-> (hrdata[pmr_pkg::WS_BIT] == ws_q))
    else $error("wake status read back wrong");

  csr_we_read_a: assert property (
    csr_read_s |-> (hrdata[pmr_pkg::WE_BIT] == we_q))
    else $error("wake enable read back wrong");

  csr_ps_read_a: assert property (
    csr_read_s |-> (hrdata[1:0] == ps_q))
    else $error("power state read back wrong");

  ext_bpcc_a: assert property (
    ext_read_s |-> hrdata[7])
    else $error("bus power control bit not set");

  ext_b2b3_a: assert property (
    ext_read_s |-> hrdata[6])
    else $error("secondary bus support bit not set");

  ext_low_zero_a: assert property (
    ext_read_s |-> (hrdata[5:0] == 6'h00))
    else $error("extension low bits not zero");

  ////////////////////////////////////////////////////////////////////////////
  // Wake status and power-state sequencing

  set_wins_a: assert property (
    ws_write1_s ##0 wake_event |=> ws_q)
    else $error("event lost against a clearing write");

  zero_write_a: assert property (
    ws_write0_s |=> (ws_q == ($past(ws_q) || $past(wake_event))))
    else $error("write of zero changed wake status");

  wake_release_a: assert property (
    !ws_q |-> wake_n)
    else $error("wake driven with status clear");

  ws_rose_a: assert property (
    $rose(ws_q) |-> $past(wake_event))
    else $error("wake status set without an event");

  ps_out_a: assert property (
    power_state == ps_q)
    else $error("power state output differs from field");

  ps_hold_a: assert property (
    !csr_wr |=> (ps_q == $past(ps_q)))
    else $error("power state moved without a write");

  we_hold_a: assert property (
    !csr_wr |=> (we_q == $past(we_q)))
    else $error("wake enable moved without a write");

  frst_cause_a: assert property (
    func_reset |-> $past(csr_wr) && ($past(ps_q) == pmr_pkg::PMR_D3HOT)
      && (ps_q == pmr_pkg::PMR_D0))
    else $error("internal reset without a D3hot exit");

endmodule : pmr_regs

// file: testbench/pmr_host.sv
// Host model: single-word AHB-Lite master for configuration access
`timescale 1ns/1ps

module pmr_host (
  input  wire logic        hclk,   // Bus clock
  input  wire logic        hready, // Bus ready, sampled at rising edge
  input  wire logic [31:0] hrdata, // Read data
  output logic      [31:0] haddr,  // Byte address
  output logic      [1:0]  htrans, // Transfer type
  output logic             hwrite, // Write when high
  output logic      [31:0] hwdata  // Write data
);
  initial
  begin
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
  end

  // Entered just after a rising edge; only the watchdog ends a stuck wait
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] r);
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hready !== 1'b1)
      @(posedge hclk);
    htrans <= 2'h0;
    // Reads toggle the data lines so a stale word never looks valid
    hwdata <= w ? d : ~hwdata;
    @(posedge hclk);
    while (hready !== 1'b1)
      @(posedge hclk);
    r = hrdata;
  endtask : xfer
endmodule : pmr_host

// file: testbench/testbench.sv
// Testbench: model-checked register, wake and power-state scenarios
`timescale 1ns/1ps

module testbench;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        wake_event = 1'b0;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0]  htrans, power_state;
  logic        hwrite, hreadyout, hresp, wake_n, func_reset;
  integer      fails = 0, checked = 0, seed = 19, ws = 0, we = 0, ps = 0, i;

  always #2 hclk = ~hclk;

  pmr_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .wake_event(wake_event), .wake_n(wake_n),
    .power_state(power_state), .func_reset(func_reset));
  pmr_host host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata));

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    host.xfer(1'b0, {20'h0, a}, 32'h0, r);
    chk(r, e);
  endtask : rd

  task automatic wr(input logic [31:0] v);
    logic [31:0] r;
    logic        fr;
    fr = (ps == 3) && (v[1:0] == 2'h0);
    host.xfer(1'b1, {20'h0, pmr_pkg::CSR_ADDR}, v, r);
    ws = v[15] ? 0 : ws;
    we = v[8];
    ps = v[1:0];
    #1;
    chk(32'(func_reset), 32'(fr));
    chk(32'(power_state), ps);
    @(posedge hclk);
    chk(32'(wake_n), 32'(!(ws && we)));
    // Random upper bits make the reserved fields show any stuck one
    rd(pmr_pkg::CSR_ADDR, (ws << 15) | (we << 8) | ps);
  endtask : wr

  task automatic ev;
    wake_event <= 1'b1;
    @(posedge hclk);
    wake_event <= 1'b0;
    ws = 1;
    @(posedge hclk);
    #1;
    chk(32'(wake_n), 32'(!(ws && we)));
  endtask : ev

  task automatic end_of_test;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    #20000;
    fails++;
    end_of_test;
  end

  initial
  begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(pmr_pkg::CAP_ADDR, 32'h221);
    rd(pmr_pkg::CSR_ADDR, 32'h0);
    rd(pmr_pkg::EXT_ADDR, 32'hC0);
    rd(12'h294, 32'h0);
    host.xfer(1'b1, {20'h0, pmr_pkg::EXT_ADDR}, 32'hFFFFFFFF, d);
    rd(pmr_pkg::EXT_ADDR, 32'hC0);
    host.xfer(1'b1, {20'h0, pmr_pkg::CAP_ADDR}, 32'hFFFFFFFF, d);
    rd(pmr_pkg::CAP_ADDR, 32'h221);
    $display("test read-only done");
    // States run 3,0,1,2 so the D3hot to D0 step is hit three times
    for (i = 0; i < 12; i++)
    begin
      d = $random(seed);
      d[15] = 1'b0;
      d[1:0] = 2'(i + 3);
      wr(d);
    end
    $display("test power states done");
    wr(32'h100);
    ev;
    wr(32'h100);
    wr(32'h8100);
    wr(32'h3);
    ev;
    wr(32'h0);
    wr(32'h100);
    // Event lands in the data phase of a clearing write: set must win
    fork
      host.xfer(1'b1, {20'h0, pmr_pkg::CSR_ADDR}, 32'h8100, d);
      begin
        @(posedge hclk);
        wake_event <= 1'b1;
        @(posedge hclk);
        wake_event <= 1'b0;
      end
    join
    rd(pmr_pkg::CSR_ADDR, 32'h8100);
    chk(32'(wake_n), 32'h0);
    chk({30'h0, hreadyout, hresp}, 32'h2);
    $display("test wake done");
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    ws = 0;
    we = 0;
    ps = 0;
    @(posedge hclk);
    rd(pmr_pkg::CSR_ADDR, 32'h0);
    chk(32'(wake_n), 32'h1);
    $display("test bus reset done");
    end_of_test;
  end
endmodule : testbench
